// ---- pkg/amux_defines.vh ----
// amux_defines.vh: offsets, field positions, reset values and codes
// assumes: included by bare name from the design files
`ifndef AMUX_DEFINES_VH
`define AMUX_DEFINES_VH

// ---------------------------------------------------------------
// register addresses on the core's special function register bus
// ---------------------------------------------------------------
`define AMUX_ADDR_PAIR_CFG   8'hBA
`define AMUX_ADDR_CHAN_SEL   8'hBB
`define AMUX_ADDR_PIN_SEL    8'hBD
`define AMUX_ADDR_HV_CTRL    8'hD6
`define AMUX_ADDR_CONV_CTRL  8'hE8

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define AMUX_RST_PAIR_CFG    4'h0
`define AMUX_RST_CHAN_SEL    4'h0
`define AMUX_RST_PIN_SEL     8'h00
`define AMUX_RST_HV_CTRL     8'h00
`define AMUX_RST_CONV_CTRL   8'h00

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define AMUX_CFG_PORT_BIT    3
`define AMUX_CFG_HV_BIT      2
`define AMUX_CFG_EXTB_BIT    1
`define AMUX_CFG_EXTA_BIT    0
`define AMUX_HV_EN_BIT       7
`define AMUX_HV_GAIN_MSB     3
`define AMUX_HV_GAIN_LSB     0
`define AMUX_CONV_EN_BIT     7

// ---------------------------------------------------------------
// one-hot source selects on the positive mux side
// ---------------------------------------------------------------
`define AMUX_SRC_W           9
`define AMUX_SRC_EXT0        0
`define AMUX_SRC_EXT1        1
`define AMUX_SRC_EXT2        2
`define AMUX_SRC_EXT3        3
`define AMUX_SRC_HV          4
`define AMUX_SRC_GND         5
`define AMUX_SRC_PEVEN       6
`define AMUX_SRC_PODD        7
`define AMUX_SRC_TEMP        8

// ---------------------------------------------------------------
// one-hot selects on the negative mux side
// ---------------------------------------------------------------
`define AMUX_NEG_W           5
`define AMUX_NEG_GND         0
`define AMUX_NEG_EXT1        1
`define AMUX_NEG_EXT3        2
`define AMUX_NEG_HIGH_VOLTAGE_AMP_REFERENCE       3
`define AMUX_NEG_PODD        4

`endif

// ---- rtl/amux_sfr_reg.v ----
// amux_sfr_reg.v: one byte-wide special function register
// assumes: write strobe and address come from the core on sys_clk
`timescale 1ns/1ps
`include "amux_defines.vh"

module amux_sfr_reg #(
  parameter [7:0] ADDR  = 8'h00,
  parameter       WIDTH = 8,
  parameter [WIDTH-1:0] RST = {WIDTH{1'b0}}
) (
  input  wire             sys_clk,
  input  wire             arst_n,
  input  wire             sfr_wr,
  input  wire [7:0]       sfr_addr,
  input  wire [7:0]       sfr_wdata,
  output reg  [WIDTH-1:0] value,
  output wire [7:0]       rd_byte,
  output wire             hit
);

  // ---------------------------------------------------------------
  // decode and storage
  // ---------------------------------------------------------------
  assign hit = (sfr_addr == ADDR);

  // upper bits outside WIDTH are never stored
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      value <= RST;
    end else if (sfr_wr && hit) begin
      value <= sfr_wdata[WIDTH-1:0];
    end
  end

  // unused upper bits read as zero
  generate
    if (WIDTH < 8) begin : g_pad
      assign rd_byte = {{(8-WIDTH){1'b0}}, value};
    end else begin : g_full
      assign rd_byte = value;
    end
  endgenerate

endmodule // amux_sfr_reg

// ---- rtl/amux_chan_decode.v ----
// amux_chan_decode.v: channel code plus pair bits to mux selects
// assumes: inputs are stable register outputs on the same clock
`timescale 1ns/1ps
`include "amux_defines.vh"

module amux_chan_decode (
  input  wire [3:0]             channel_code,
  input  wire                   ext_pair_a_diff,
  input  wire                   ext_pair_b_diff,
  input  wire                   hv_amp_diff,
  input  wire                   port_pair_diff,
  output reg  [`AMUX_SRC_W-1:0] pos_sel,
  output reg  [`AMUX_NEG_W-1:0] neg_sel,
  output reg                    diff_mode
);

  // ---------------------------------------------------------------
  // selection chart as one case; odd code of a differential pair falls to its even
  // ---------------------------------------------------------------
  always @* begin
    pos_sel   = {`AMUX_SRC_W{1'b0}};
    neg_sel   = {`AMUX_NEG_W{1'b0}};
    diff_mode = 1'b0;
    neg_sel[`AMUX_NEG_GND] = 1'b1;
    if (channel_code[3]) begin
      pos_sel[`AMUX_SRC_TEMP] = 1'b1;
    end else begin
      case (channel_code[2:1])
        2'b00: begin
          if (ext_pair_a_diff) begin
            pos_sel[`AMUX_SRC_EXT0] = 1'b1;
            neg_sel = {`AMUX_NEG_W{1'b0}};
            neg_sel[`AMUX_NEG_EXT1] = 1'b1;
            diff_mode = 1'b1;
          end else if (channel_code[0]) begin
            pos_sel[`AMUX_SRC_EXT1] = 1'b1;
          end else begin
            pos_sel[`AMUX_SRC_EXT0] = 1'b1;
          end
        end
        2'b01: begin
          if (ext_pair_b_diff) begin
            pos_sel[`AMUX_SRC_EXT2] = 1'b1;
            neg_sel = {`AMUX_NEG_W{1'b0}};
            neg_sel[`AMUX_NEG_EXT3] = 1'b1;
            diff_mode = 1'b1;
          end else if (channel_code[0]) begin
            pos_sel[`AMUX_SRC_EXT3] = 1'b1;
          end else begin
            pos_sel[`AMUX_SRC_EXT2] = 1'b1;
          end
        end
        2'b10: begin
          if (hv_amp_diff) begin
            pos_sel[`AMUX_SRC_HV] = 1'b1;
            neg_sel = {`AMUX_NEG_W{1'b0}};
            neg_sel[`AMUX_NEG_HIGH_VOLTAGE_AMP_REFERENCE] = 1'b1;
            diff_mode = 1'b1;
          end else if (channel_code[0]) begin
            pos_sel[`AMUX_SRC_GND] = 1'b1;
          end else begin
            pos_sel[`AMUX_SRC_HV] = 1'b1;
          end
        end
        2'b11: begin
          if (port_pair_diff) begin
            pos_sel[`AMUX_SRC_PEVEN] = 1'b1;
            neg_sel = {`AMUX_NEG_W{1'b0}};
            neg_sel[`AMUX_NEG_PODD] = 1'b1;
            diff_mode = 1'b1;
          end else if (channel_code[0]) begin
            pos_sel[`AMUX_SRC_PODD] = 1'b1;
          end else begin
            pos_sel[`AMUX_SRC_PEVEN] = 1'b1;
          end
        end
        default: begin
          pos_sel[`AMUX_SRC_GND] = 1'b1;
        end
      endcase
    end
  end

endmodule // amux_chan_decode

// ---- rtl/amux_top.v ----
// amux_top.v: analog input mux selection for the sar converter
// assumes: the core drives a byte-wide sfr bus on sys_clk; analog
// switches outside take the registered selects below, one-hot while the converter is on and all zero while off
// the temperature sensor and amplifier sit behind the same mux
`timescale 1ns/1ps
`include "amux_defines.vh"

module amux_top (
  input  wire                   sys_clk,
  input  wire                   arst_n,
  input  wire                   sfr_wr,
  input  wire                   sfr_rd,
  input  wire [7:0]             sfr_addr,
  input  wire [7:0]             sfr_wdata,
  output reg  [7:0]             sfr_rdata,
  output wire                   sfr_hit,
  output reg  [`AMUX_SRC_W-1:0] mux_pos_sel,
  output reg  [`AMUX_NEG_W-1:0] mux_neg_sel,
  output reg  [7:0]             port_pin_connect,
  output reg  [7:0]             port_even_tap,
  output reg  [7:0]             port_odd_tap,
  output reg                    twos_complement,
  output reg                    hv_amp_enable,
  output reg  [3:0]             hv_amp_gain_code,
  output reg                    converter_active
);

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  // held register values
  wire [3:0] pair_cfg;
  wire [3:0] chan_code;
  wire [7:0] pin_sel;
  wire [7:0] hv_ctrl;
  wire [7:0] conv_ctrl;
  // read-back bytes, upper bits padded
  wire [7:0] rd_cfg;
  wire [7:0] rd_chan;
  wire [7:0] rd_pin;
  wire [7:0] rd_hv;
  wire [7:0] rd_conv;
  // address matches, one per register
  wire       hit_cfg;
  wire       hit_chan;
  wire       hit_pin;
  wire       hit_hv;
  wire       hit_conv;

  // four-bit wide store drops the upper nibble on write
  amux_sfr_reg #(
    .ADDR  (`AMUX_ADDR_PAIR_CFG),
    .WIDTH (4),
    .RST   (`AMUX_RST_PAIR_CFG)
  ) u_pair_cfg (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .sfr_wr    (sfr_wr),
    .sfr_addr  (sfr_addr),
    .sfr_wdata (sfr_wdata),
    .value     (pair_cfg),
    .rd_byte   (rd_cfg),
    .hit       (hit_cfg)
  );

  // channel code in bits 3:0, upper nibble reads zero
  amux_sfr_reg #(
    .ADDR  (`AMUX_ADDR_CHAN_SEL),
    .WIDTH (4),
    .RST   (`AMUX_RST_CHAN_SEL)
  ) u_chan_sel (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .sfr_wr    (sfr_wr),
    .sfr_addr  (sfr_addr),
    .sfr_wdata (sfr_wdata),
    .value     (chan_code),
    .rd_byte   (rd_chan),
    .hit       (hit_chan)
  );

  // one enable per port pin, bit n for pin n
  amux_sfr_reg #(
    .ADDR  (`AMUX_ADDR_PIN_SEL),
    .WIDTH (8),
    .RST   (`AMUX_RST_PIN_SEL)
  ) u_pin_sel (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .sfr_wr    (sfr_wr),
    .sfr_addr  (sfr_addr),
    .sfr_wdata (sfr_wdata),
    .value     (pin_sel),
    .rd_byte   (rd_pin),
    .hit       (hit_pin)
  );

  // amplifier control; stored whole, bits 6:4 have no effect
  amux_sfr_reg #(
    .ADDR  (`AMUX_ADDR_HV_CTRL),
    .WIDTH (8),
    .RST   (`AMUX_RST_HV_CTRL)
  ) u_hv_ctrl (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .sfr_wr    (sfr_wr),
    .sfr_addr  (sfr_addr),
    .sfr_wdata (sfr_wdata),
    .value     (hv_ctrl),
    .rd_byte   (rd_hv),
    .hit       (hit_hv)
  );

  // only the enable bit is used here; the rest belongs to the sequencer
  amux_sfr_reg #(
    .ADDR  (`AMUX_ADDR_CONV_CTRL),
    .WIDTH (8),
    .RST   (`AMUX_RST_CONV_CTRL)
  ) u_conv_ctrl (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .sfr_wr    (sfr_wr),
    .sfr_addr  (sfr_addr),
    .sfr_wdata (sfr_wdata),
    .value     (conv_ctrl),
    .rd_byte   (rd_conv),
    .hit       (hit_conv)
  );

  // any of the five held addresses answers on the bus
  assign sfr_hit = hit_cfg | hit_chan | hit_pin | hit_hv | hit_conv;

  // ---------------------------------------------------------------
  // read data, registered; unmapped addresses return zero
  // ---------------------------------------------------------------
  reg [7:0] next_rdata;

  // addresses never overlap, so the priority order is moot
  always @* begin
    next_rdata = 8'h00;
    if (hit_cfg) begin
      next_rdata = rd_cfg;
    end else if (hit_chan) begin
      next_rdata = rd_chan;
    end else if (hit_pin) begin
      next_rdata = rd_pin;
    end else if (hit_hv) begin
      next_rdata = rd_hv;
    end else if (hit_conv) begin
      next_rdata = rd_conv;
    end
  end

  // data holds between strobes so the core may sample it late
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // channel decode
  // ---------------------------------------------------------------
  // decoded selects ahead of the output flops
  wire [`AMUX_SRC_W-1:0] dec_pos;
  wire [`AMUX_NEG_W-1:0] dec_neg;
  wire                   dec_diff;

  // pair bits handed over by field position
  amux_chan_decode u_decode (
    .channel_code    (chan_code),
    .ext_pair_a_diff (pair_cfg[`AMUX_CFG_EXTA_BIT]),
    .ext_pair_b_diff (pair_cfg[`AMUX_CFG_EXTB_BIT]),
    .hv_amp_diff     (pair_cfg[`AMUX_CFG_HV_BIT]),
    .port_pair_diff  (pair_cfg[`AMUX_CFG_PORT_BIT]),
    .pos_sel         (dec_pos),
    .neg_sel         (dec_neg),
    .diff_mode       (dec_diff)
  );

  // ---------------------------------------------------------------
  // port pin routing
  // ---------------------------------------------------------------
  // even taps only ever see even pins, odd taps odd pins; any mix is
  // allowed, same-parity pins meet on one node (wired-or outside)
  // the parity split is fixed wiring; only the enables are held
  reg [7:0] next_even_tap;
  reg [7:0] next_odd_tap;
  integer   pin_idx;

  // split the enabled pins by the parity of their pin number
  always @* begin
    next_even_tap = 8'h00;
    next_odd_tap  = 8'h00;
    for (pin_idx = 0; pin_idx < 8; pin_idx = pin_idx + 1) begin
      if (pin_idx % 2 == 0) begin
        next_even_tap[pin_idx] = pin_sel[pin_idx];
      end else begin
        next_odd_tap[pin_idx] = pin_sel[pin_idx];
      end
    end
  end

  // ---------------------------------------------------------------
  // control bits picked out of the held registers
  // ---------------------------------------------------------------
  // reserved amplifier bits 6:4 are held for read-back only
  // converter control bits 6:0 belong to the conversion sequencer
  wire       conv_en = conv_ctrl[`AMUX_CONV_EN_BIT];
  wire       hv_en   = hv_ctrl[`AMUX_HV_EN_BIT];
  wire [3:0] hv_gain = hv_ctrl[`AMUX_HV_GAIN_MSB:`AMUX_HV_GAIN_LSB];

  // ---------------------------------------------------------------
  // mux switch selects; everything opens while the converter is off
  // ---------------------------------------------------------------
  // switches drop during shutdown to save power; a settled channel is
  // lost, so software must allow tracking time after enabling
  // selects are one-hot while the converter is on and all zero while off; the analog side never sees two paths
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mux_pos_sel      <= {`AMUX_SRC_W{1'b0}};
      mux_neg_sel      <= {`AMUX_NEG_W{1'b0}};
      converter_active <= 1'b0;
    end else begin
      converter_active <= conv_en;
      if (conv_en) begin
        mux_pos_sel <= dec_pos;
        mux_neg_sel <= dec_neg;
      end else begin
        mux_pos_sel <= {`AMUX_SRC_W{1'b0}};
        mux_neg_sel <= {`AMUX_NEG_W{1'b0}};
      end
    end
  end

  // ---------------------------------------------------------------
  // data format flag
  // ---------------------------------------------------------------
  // not gated by the enable, so the data path knows the format of
  // the channel set up before the converter is turned on
  // its settled value is ready the moment the switches close
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      twos_complement <= 1'b0;
    end else begin
      twos_complement <= dec_diff;
    end
  end

  // ---------------------------------------------------------------
  // port pin switches
  // ---------------------------------------------------------------
  // pins stay connected while the converter sleeps; only the mux
  // switches open, so pin loading stays as software set it
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      port_pin_connect <= 8'h00;
      port_even_tap    <= 8'h00;
      port_odd_tap     <= 8'h00;
    end else begin
      port_pin_connect <= pin_sel;
      port_even_tap    <= next_even_tap;
      port_odd_tap     <= next_odd_tap;
    end
  end

  // ---------------------------------------------------------------
  // high-voltage amplifier controls
  // ---------------------------------------------------------------
  // gain and enable pass straight through; the analog side settles
  // in its own time, which software has to wait out
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hv_amp_enable    <= 1'b0;
      hv_amp_gain_code <= 4'h0;
    end else begin
      hv_amp_enable    <= hv_en;
      hv_amp_gain_code <= hv_gain;
    end
  end

endmodule // amux_top

// ---- tb/amux_top_props.sv ----
// amux_top_props.sv: port checker for the mux select block
// assumes: bound onto amux_top; one clock, async active-low reset
`timescale 1ns/1ps
`include "amux_defines.vh"

module amux_top_props (
  input wire logic                   sys_clk,
  input wire logic                   arst_n,
  input wire logic                   sfr_wr,
  input wire logic                   sfr_rd,
  input wire logic [7:0]             sfr_addr,
  input wire logic [7:0]             sfr_wdata,
  input wire logic [7:0]             sfr_rdata,
  input wire logic                   sfr_hit,
  input wire logic [`AMUX_SRC_W-1:0] mux_pos_sel,
  input wire logic [`AMUX_NEG_W-1:0] mux_neg_sel,
  input wire logic [7:0]             port_pin_connect,
  input wire logic [7:0]             port_even_tap,
  input wire logic [7:0]             port_odd_tap,
  input wire logic                   twos_complement,
  input wire logic                   hv_amp_enable,
  input wire logic [3:0]             hv_amp_gain_code,
  input wire logic                   converter_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // ------
  // register writes, seen two edges later
  // ------
  sequence wr_pin;  sfr_wr && sfr_addr == 8'hBD; endsequence
  sequence wr_hv;   sfr_wr && sfr_addr == 8'hD6; endsequence
  sequence wr_conv; sfr_wr && sfr_addr == 8'hE8; endsequence

  a_pin_write_lag: assert property (
    wr_pin |-> ##2 port_pin_connect == $past(sfr_wdata, 2))
    else $error("pin select output wrong after write");
  a_hv_write_lag: assert property (
    wr_hv |-> ##2 hv_amp_enable == $past(sfr_wdata[7], 2) &&
      hv_amp_gain_code == $past(sfr_wdata[3:0], 2))
    else $error("amplifier control outputs wrong after write");
  a_conv_write_lag: assert property (
    wr_conv |-> ##2 converter_active == $past(sfr_wdata[7], 2))
    else $error("converter enable wrong after write");
  // upper nibble of both config registers never reads back
  a_nib_read_zero: assert property (
    sfr_rd && (sfr_addr == 8'hBA || sfr_addr == 8'hBB)
      |=> sfr_rdata[7:4] == 4'h0)
    else $error("upper nibble read nonzero");
  a_unmapped_read: assert property (sfr_rd && !sfr_hit
    |=> sfr_rdata == 8'h00)
    else $error("unmapped read returned data");
  // switches open in shutdown, exactly one path when active
  a_off_open: assert property (!converter_active
    |-> mux_pos_sel == 9'h000 && mux_neg_sel == 5'h00)
    else $error("mux closed while converter off");
  a_sel_onehot: assert property (converter_active
    |-> $onehot(mux_pos_sel) && $onehot(mux_neg_sel))
    else $error("mux select not one-hot");
  a_twos_neg_tie: assert property (converter_active
    |-> twos_complement == !mux_neg_sel[`AMUX_NEG_GND])
    else $error("data format disagrees with negative side");
  a_hv_ref_neg: assert property (
    converter_active && twos_complement && mux_pos_sel[`AMUX_SRC_HV]
      |-> mux_neg_sel[`AMUX_NEG_HIGH_VOLTAGE_AMP_REFERENCE])
    else $error("amplifier reference not on negative side");
  a_parity_taps: assert property (
    port_even_tap == (port_pin_connect & 8'h55) &&
      port_odd_tap == (port_pin_connect & 8'hAA))
    else $error("port parity taps wrong");
endmodule // amux_top_props

bind amux_top amux_top_props amux_top_props_inst (.sys_clk, .arst_n,
  .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata, .sfr_hit,
  .mux_pos_sel, .mux_neg_sel, .port_pin_connect, .port_even_tap,
  .port_odd_tap, .twos_complement, .hv_amp_enable, .hv_amp_gain_code,
  .converter_active);

// ---- tb/amux_top_tb_top.sv ----
// amux_top_tb_top.sv: self-checking bench for the mux select block
// assumes: amux_top alone; bench drives the sfr bus at falling edges
`timescale 1ns/1ps
`include "amux_defines.vh"

module amux_top_tb_top;
  logic                   sys_clk, arst_n, sfr_wr, sfr_rd, sfr_hit;
  logic [7:0]             sfr_addr, sfr_wdata, sfr_rdata;
  logic [`AMUX_SRC_W-1:0] mux_pos_sel;
  logic [`AMUX_NEG_W-1:0] mux_neg_sel;
  logic [7:0]             port_pin_connect, port_even_tap, port_odd_tap;
  logic                   twos_complement, hv_amp_enable;
  logic                   converter_active;
  logic [3:0]             hv_amp_gain_code;
  logic [14:0]            e;
  logic [7:0]             pins [3] = '{8'hA5, 8'h3C, 8'hFF};
  logic [7:0]             regs [5] = '{8'hBA, 8'hBB, 8'hBD, 8'hD6, 8'hE8};
  int                     fail_count = 0, n_compared = 0, cycles = 0;

  amux_top amux_top_inst (.sys_clk, .arst_n, .sfr_wr, .sfr_rd,
    .sfr_addr, .sfr_wdata, .sfr_rdata, .sfr_hit, .mux_pos_sel,
    .mux_neg_sel, .port_pin_connect, .port_even_tap, .port_odd_tap,
    .twos_complement, .hv_amp_enable, .hv_amp_gain_code,
    .converter_active);

  // ------
  // clock and hang guard
  // ------
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ceiling well above the ~1050 cycles the sweep needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      close_out;
    end
  end

  // ------
  // compare, report, bus tasks
  // ------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one-cycle strobe; a gap edge follows so strobes never merge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfr_wr = 1'b1; sfr_addr = a; sfr_wdata = d;
    @(negedge sys_clk);
    sfr_wr = 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    sfr_rd = 1'b1; sfr_addr = a;
    @(negedge sys_clk);
    sfr_rd = 1'b0;
    chk(sfr_rdata, exp);
  endtask
  // outputs trail the register by one edge; also the settling wait
  // after an amplifier channel is selected
  task settle;
    repeat (2) @(negedge sys_clk);
  endtask

  // expected {twos, neg, pos}: pair k takes code bits 2:1
  function automatic logic [14:0] exp_sel(input logic [3:0] cf,
                                          input logic [3:0] c);
    logic [8:0] p;
    logic [4:0] n;
    logic [1:0] k;
    logic       d;
    p = 9'h000; n = 5'h00; k = c[2:1]; d = cf[k] & ~c[3];
    if (c[3]) p[`AMUX_SRC_TEMP] = 1'b1;
    else p[{k, c[0] & ~d}] = 1'b1;
    if (!d) n[`AMUX_NEG_GND] = 1'b1;
    else n[k == 2'h0 ? `AMUX_NEG_EXT1 : k == 2'h1 ? `AMUX_NEG_EXT3 :
           k == 2'h2 ? `AMUX_NEG_HIGH_VOLTAGE_AMP_REFERENCE : `AMUX_NEG_PODD] = 1'b1;
    return {d, n, p};
  endfunction

  // ------
  // main sequence
  // ------
  initial begin
    sfr_wr = 1'b0; sfr_rd = 1'b0; sfr_addr = 8'h00; sfr_wdata = 8'h00;
    arst_n = 1'b0;
    repeat (20) @(negedge sys_clk);
    arst_n = 1'b1;
    foreach (regs[i]) rdc(regs[i], 8'h00);
    wr(8'hBA, 8'hF0);
    rdc(8'hBA, 8'h00);
    wr(8'hBB, 8'hFF);
    rdc(8'hBB, 8'h0F);
    chk(sfr_hit, 1'b1);
    wr(8'hBC, 8'h5A);
    rdc(8'hBC, 8'h00);
    chk(sfr_hit, 1'b0);
    // every code against every pair setting
    wr(8'hE8, 8'h80);
    settle;
    chk(converter_active, 1'b1);
    for (int cf = 0; cf < 16; cf++) begin
      wr(8'hBA, cf[7:0]);
      for (int c = 0; c < 16; c++) begin
        wr(8'hBB, c[7:0]);
        settle;
        e = exp_sel(cf[3:0], c[3:0]);
        chk(mux_pos_sel, e[8:0]);
        chk(mux_neg_sel, e[13:9]);
        chk(twos_complement, e[14]);
      end
    end
    // shutdown opens switches but the format flag still follows the channel
    wr(8'hE8, 8'h00);
    wr(8'hBB, 8'h06);
    settle;
    chk({mux_pos_sel, mux_neg_sel, converter_active}, 15'h0000);
    chk(twos_complement, 1'b1);
    foreach (pins[i]) begin
      wr(8'hBD, pins[i]);
      settle;
      chk(port_pin_connect, pins[i]);
      chk(port_even_tap, pins[i] & 8'h55);
      chk(port_odd_tap, pins[i] & 8'hAA);
      rdc(8'hBD, pins[i]);
    end
    wr(8'hD6, 8'h8F);
    settle;
    chk({hv_amp_enable, hv_amp_gain_code}, 5'h1F);
    rdc(8'hD6, 8'h8F);
    wr(8'hD6, 8'h05);
    settle;
    chk({hv_amp_enable, hv_amp_gain_code}, 5'h05);
    // reset in mid-run clears without a clock edge
    @(negedge sys_clk);
    arst_n = 1'b0;
    #1;
    chk({port_pin_connect, hv_amp_gain_code}, 12'h000);
    @(negedge sys_clk);
    arst_n = 1'b1;
    rdc(8'hBA, 8'h00);
    close_out;
  end
endmodule // amux_top_tb_top
